/* logic/lhb_pkg.sv */
// Purpose: shared constants for the display host bus interface
// Assumes: one clock, host pins synchronous to mclk
// Notes: status bit positions and fifo sizing
package lhb_pkg;
  localparam int unsigned LHB_DATA_W = 8;
  localparam int unsigned LHB_FIFO_DEPTH = 4;
  localparam int unsigned LHB_ADDR_W = 16;
  localparam int unsigned LHB_ST_BUSY = 7;
  localparam int unsigned LHB_ST_SEGDIR = 6;
  localparam int unsigned LHB_ST_DISPON = 5;
  localparam int unsigned LHB_ST_RESET = 4;
  localparam logic [7:0] LHB_BYTE_ZERO = 8'h00;
  localparam logic [2:0] LHB_BITS_LAST = 3'h7;
  localparam logic [2:0] LHB_BITS_ZERO = 3'h0;
  typedef enum logic [1:0] {
    LHB_RD_IDLE = 2'b00,
    LHB_RD_FETCH = 2'b01,
    LHB_RD_WAIT = 2'b10
  } lhb_rd_state_t;
endpackage

/* logic/lhb_host_bus.sv */
// Purpose: host port of a display driver, serial or 8-bit parallel, two strobe styles
// Assumes: host pins synchronous to mclk; ram answers one cycle after its read request
// Notes: four byte write fifo in front of display ram; ram read data lags one read
// Notes on behaviour
// - transfers are taken only while select_active_low is low and select_active_high is high.
// - when not selected the select, strobes and data are ignored and the data lines float.
// - in serial mode a deselect clears the shift register and the bit counter.
// - serial_parallel_choice high means parallel, low means serial, style pin ignored in serial.
// - parallel data is one bidirectional byte, driven only during reads.
// - bus_style_choice high selects enable plus direction, low selects separate strobes.
// - in enable style a transfer happens while enable is high, direction high reads.
// - in separate style read low with write high reads, write low with read high writes.
// - register_or_ram_select high reads and writes display ram data.
// - register_or_ram_select low reads status and writes instruction bytes.
// - a ram write latches into the four byte write fifo and moves on to ram on its own.
// - a ram read returns the holder and then refills it from ram at the current address.
// - the first ram read after an address change does not show the addressed byte.
// - status reads give busy, segment direction, display on and reset flag in bits 7 to 4.

// ************************************************************
// fifo
// ************************************************************
module lhb_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire do_push = in_valid && in_ready;
  wire do_pop = out_valid && out_ready;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (do_pop) rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
  always_ff @(posedge mclk) begin
    if (do_push) mem[wr_ptr] <= in_data;
  end

  // ************************************************************
  // fifo checks
  // ************************************************************
  a_fifo_bound: assert property (@(posedge mclk) disable iff (reset)
    count <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
  a_fifo_stall: assert property (@(posedge mclk) disable iff (reset)
    !in_ready && !out_ready |=> $stable(count))
    else $error("full fifo changed without drain");
  a_fifo_push: assert property (@(posedge mclk) disable iff (reset)
    do_push && !do_pop |=> count == $past(count) + 1'b1)
    else $error("fifo push not counted");
  a_fifo_pop: assert property (@(posedge mclk) disable iff (reset)
    do_pop && !do_push |=> count == $past(count) - 1'b1)
    else $error("fifo pop not counted");
  a_fifo_hold: assert property (@(posedge mclk) disable iff (reset)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("fifo head changed while stalled");
endmodule

// ************************************************************
// host bus
// ************************************************************
module lhb_host_bus (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // host pins
  input wire logic select_active_low,
  input wire logic select_active_high,
  input wire logic serial_parallel_choice,
  input wire logic bus_style_choice,
  input wire logic register_or_ram_select,
  input wire logic strobe_e_rd,
  input wire logic strobe_rw_wr,
  input wire logic [lhb_pkg::LHB_DATA_W-1:0] host_data_in,
  output logic [lhb_pkg::LHB_DATA_W-1:0] host_data_out,
  output logic host_data_oe,
  input wire logic serial_clk,
  input wire logic serial_data,
  // display ram side
  output logic ram_wr_valid,
  input wire logic ram_wr_ready,
  output logic [lhb_pkg::LHB_DATA_W-1:0] ram_wr_data,
  output logic ram_rd_req,
  input wire logic [lhb_pkg::LHB_DATA_W-1:0] ram_rd_data,
  input wire logic ram_addr_changed,
  // instruction decoder side
  output logic instr_valid,
  output logic [lhb_pkg::LHB_DATA_W-1:0] instr_data,
  // status flags
  input wire logic busy_flag,
  input wire logic seg_dir_flag,
  input wire logic display_on_flag,
  input wire logic reset_in_progress_flag,
  // serial receive, plus write fifo full on serial_busy
  output logic serial_byte_valid,
  output logic [lhb_pkg::LHB_DATA_W-1:0] serial_byte,
  output logic serial_busy
);
  import lhb_pkg::*;

  // ************************************************************
  // decode
  // ************************************************************
  wire selected = !select_active_low && select_active_high;
  wire par_mode = serial_parallel_choice;
  wire par_sel = selected && par_mode;
  wire e_style = bus_style_choice;
  wire rd_act = e_style ? (strobe_e_rd && strobe_rw_wr) : (!strobe_e_rd && strobe_rw_wr);
  wire wr_act = e_style ? (strobe_e_rd && !strobe_rw_wr) : (strobe_e_rd && !strobe_rw_wr);
  logic rd_prev;
  logic wr_prev;
  wire rd_start = par_sel && rd_act && !rd_prev;
  wire wr_start = par_sel && wr_act && !wr_prev;
  wire ram_write = wr_start && register_or_ram_select;
  wire ins_write = wr_start && !register_or_ram_select;
  wire ram_read = rd_start && register_or_ram_select;
  wire stat_read = rd_start && !register_or_ram_select;
  wire [7:0] status_byte = {busy_flag, seg_dir_flag, display_on_flag,
                            reset_in_progress_flag, 4'h0};
  logic [7:0] holder;
  logic holder_stale;
  lhb_rd_state_t rd_state;
  lhb_rd_state_t next_rd_state;
  logic fifo_in_ready;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
    end else begin
      rd_prev <= par_sel && rd_act;
      wr_prev <= par_sel && wr_act;
    end
  end

  // ************************************************************
  // write path through the write fifo
  // ************************************************************
  lhb_fifo #(.WIDTH(LHB_DATA_W), .DEPTH(LHB_FIFO_DEPTH)) u_wr_fifo (
    .mclk(mclk),
    .reset(reset),
    .in_valid(ram_write),
    .in_ready(fifo_in_ready),
    .in_data(host_data_in),
    .out_valid(ram_wr_valid),
    .out_ready(ram_wr_ready),
    .out_data(ram_wr_data)
  );

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      instr_valid <= 1'b0;
      instr_data <= LHB_BYTE_ZERO;
    end else begin
      instr_valid <= ins_write;
      if (ins_write) instr_data <= host_data_in;
    end
  end

  // ************************************************************
  // read path with dummy read holder
  // ************************************************************
  always_comb begin
    next_rd_state = rd_state;
    unique case (rd_state)
      LHB_RD_IDLE: if (ram_read) next_rd_state = LHB_RD_FETCH;
      LHB_RD_FETCH: next_rd_state = LHB_RD_WAIT;
      LHB_RD_WAIT: next_rd_state = LHB_RD_IDLE;
      default: next_rd_state = LHB_RD_IDLE;
    endcase
  end
  assign ram_rd_req = (rd_state == LHB_RD_FETCH);
  assign serial_busy = !fifo_in_ready;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_state <= LHB_RD_IDLE;
      holder <= LHB_BYTE_ZERO;
      holder_stale <= 1'b1;
    end else begin
      rd_state <= next_rd_state;
      if (rd_state == LHB_RD_WAIT) begin
        holder <= ram_rd_data;
        holder_stale <= 1'b0;
      end
      if (ram_addr_changed) holder_stale <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      host_data_out <= LHB_BYTE_ZERO;
    end else if (stat_read) begin
      host_data_out <= status_byte;
    end else if (ram_read) begin
      host_data_out <= holder;
    end
  end
  assign host_data_oe = par_sel && rd_act;

  // ************************************************************
  // serial input
  // ************************************************************
  logic sclk_prev;
  logic [2:0] bit_cnt;
  logic [7:0] shift;
  wire ser_sel = selected && !par_mode;
  wire sclk_rise = ser_sel && serial_clk && !sclk_prev;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sclk_prev <= 1'b0;
      bit_cnt <= LHB_BITS_ZERO;
      shift <= LHB_BYTE_ZERO;
      serial_byte_valid <= 1'b0;
      serial_byte <= LHB_BYTE_ZERO;
    end else begin
      sclk_prev <= serial_clk;
      serial_byte_valid <= 1'b0;
      if (!ser_sel) begin
        bit_cnt <= LHB_BITS_ZERO;
        shift <= LHB_BYTE_ZERO;
      end else if (sclk_rise) begin
        shift <= {shift[6:0], serial_data};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == LHB_BITS_LAST) begin
          serial_byte_valid <= 1'b1;
          serial_byte <= {shift[6:0], serial_data};
        end
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_float_desel: assert property (@(posedge mclk) disable iff (reset)
    !selected |-> !host_data_oe)
    else $error("data driven while deselected");
  a_oe_read_only: assert property (@(posedge mclk) disable iff (reset)
    host_data_oe |-> rd_act && par_mode)
    else $error("data driven outside read");
  a_ser_clear: assert property (@(posedge mclk) disable iff (reset)
    (!par_mode && !selected) |=> bit_cnt == LHB_BITS_ZERO)
    else $error("serial not cleared");
  a_status_byte: assert property (@(posedge mclk) disable iff (reset)
    stat_read |=> host_data_out == {$past(busy_flag), $past(seg_dir_flag),
    $past(display_on_flag), $past(reset_in_progress_flag), 4'h0})
    else $error("bad status byte");
  a_instr_once: assert property (@(posedge mclk) disable iff (reset)
    instr_valid |=> !instr_valid)
    else $error("instruction taken twice");
  a_instr_cause: assert property (@(posedge mclk) disable iff (reset)
    instr_valid |-> $past(wr_start) && !$past(register_or_ram_select))
    else $error("instruction without write");
  a_refill_seq: assert property (@(posedge mclk) disable iff (reset)
    ram_read && rd_state == LHB_RD_IDLE |=> ram_rd_req ##1 !ram_rd_req)
    else $error("holder refill missing");
  a_read_holder: assert property (@(posedge mclk) disable iff (reset)
    ram_read && !stat_read |=> host_data_out == $past(holder))
    else $error("read not from holder");
  a_no_select: assert property (@(posedge mclk) disable iff (reset)
    !selected |=> !instr_valid)
    else $error("transfer while deselected");
  a_oe_selected: assert property (@(posedge mclk) disable iff (reset)
    host_data_oe |-> selected)
    else $error("data driven without select");
  a_serial_no_oe: assert property (@(posedge mclk) disable iff (reset)
    !par_mode |-> !host_data_oe)
    else $error("data driven in serial mode");
  a_desel_idle: assert property (@(posedge mclk) disable iff (reset)
    !selected |-> !rd_start && !wr_start)
    else $error("strobe taken while deselected");
  a_write_once: assert property (@(posedge mclk) disable iff (reset)
    wr_start |=> !wr_start)
    else $error("write strobe taken twice");
  a_read_once: assert property (@(posedge mclk) disable iff (reset)
    rd_start |=> !rd_start)
    else $error("read strobe taken twice");
  a_rdwr_excl: assert property (@(posedge mclk) disable iff (reset)
    !(rd_start && wr_start))
    else $error("read and write taken together");
  a_e_style_read: assert property (@(posedge mclk) disable iff (reset)
    par_sel && e_style && strobe_e_rd && strobe_rw_wr |-> host_data_oe)
    else $error("enable style read not driven");
  a_e_style_write: assert property (@(posedge mclk) disable iff (reset)
    par_sel && e_style && !strobe_rw_wr |-> !host_data_oe)
    else $error("enable style write driven");
  a_sep_read: assert property (@(posedge mclk) disable iff (reset)
    par_sel && !e_style && !strobe_e_rd && strobe_rw_wr |-> host_data_oe)
    else $error("strobe style read not driven");
  a_sep_write: assert property (@(posedge mclk) disable iff (reset)
    !e_style && !strobe_rw_wr |-> !host_data_oe)
    else $error("strobe style write driven");
  a_ram_push: assert property (@(posedge mclk) disable iff (reset)
    ram_write && fifo_in_ready |=> ram_wr_valid)
    else $error("ram write not offered");
  a_instr_data: assert property (@(posedge mclk) disable iff (reset)
    ins_write |=> instr_valid && instr_data == $past(host_data_in))
    else $error("instruction byte lost");
  a_stale_lag: assert property (@(posedge mclk) disable iff (reset)
    ram_read && holder_stale |=> host_data_out == $past(holder))
    else $error("stale read not from holder");
  a_refill_load: assert property (@(posedge mclk) disable iff (reset)
    rd_state == LHB_RD_WAIT |=> holder == $past(ram_rd_data))
    else $error("holder not refilled");
  a_status_busy: assert property (@(posedge mclk) disable iff (reset)
    stat_read |=> host_data_out[LHB_ST_BUSY] == $past(busy_flag))
    else $error("busy bit misplaced");
  a_status_reset: assert property (@(posedge mclk) disable iff (reset)
    stat_read |=> host_data_out[LHB_ST_RESET] == $past(reset_in_progress_flag))
    else $error("reset bit misplaced");
  a_status_low: assert property (@(posedge mclk) disable iff (reset)
    stat_read |=> host_data_out[3:0] == 4'h0)
    else $error("status low bits set");
  a_ser_shift: assert property (@(posedge mclk) disable iff (reset)
    sclk_rise |=> bit_cnt == $past(bit_cnt) + 3'h1)
    else $error("serial bit not counted");
  a_ser_byte: assert property (@(posedge mclk) disable iff (reset)
    sclk_rise && bit_cnt == LHB_BITS_LAST |=> serial_byte_valid)
    else $error("serial byte not flagged");
  a_ser_once: assert property (@(posedge mclk) disable iff (reset)
    serial_byte_valid |=> !serial_byte_valid)
    else $error("serial byte flagged twice");
  a_par_no_ser: assert property (@(posedge mclk) disable iff (reset)
    par_mode |=> !serial_byte_valid)
    else $error("serial byte in parallel mode");
endmodule

/* dv/lhb_host_model.sv */
// Purpose: host bus master model for the display host port
// Assumes: pins change just after falling mclk
// Notes: a released data bus shows the inverse of its last value
// ****************************************
// host model
// ****************************************
module lhb_host_model (
  // clock and bus level
  input wire logic mclk,
  input wire logic [7:0] bus,
  input wire logic oe,
  // host pins
  output logic sel_n,
  output logic sel,
  output logic spc,
  output logic style,
  output logic rs,
  output logic e_rd,
  output logic rw_wr,
  output logic [7:0] drv
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {sel_n, sel, spc, style, rs, e_rd, rw_wr} = 7'h53;
    drv = 8'h00;
  end
  // one strobe pulse, held three cycles, then two idle cycles
  task automatic xfer(input logic rd, input logic r, input logic [7:0] d,
                      output logic [7:0] q, output logic q_oe);
    @(negedge mclk);
    rs = r;
    drv = d;
    rw_wr = rd;
    e_rd = style | ~rd;
    repeat (3) @(negedge mclk);
    q = bus;
    q_oe = oe;
    e_rd = ~style;
    rw_wr = 1'b1;
    drv = ~drv;
    repeat (2) @(negedge mclk);
  endtask
endmodule

/* dv/lhb_host_bus_tb_top.sv */
// Purpose: self-checking bench of the display host port
// Assumes: bench acts as display ram and drives serial lines
// Notes: ram returns 8'ha0 plus the fetch count
// ****************************************
// bench
// ****************************************
module lhb_host_bus_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, reset = 1, sclk = 0, sdat = 0, wr_rdy = 0, chg = 0;
  logic busy = 0, segd = 0, dspon = 0, rstf = 0, q_oe;
  logic sel_n, sel, spc, style, rs, e_rd, rw_wr, oe, wv, rdq, iv, sv, sb;
  logic [7:0] drv, hd, hout, wd, rdd = 8'h00, idat, sbyte, q;
  logic [7:0] wq[$];
  int num_errors = 0, compares = 0, cyc = 0, n_i = 0, n_s = 0, n_rd = 0;
  assign hd = oe ? hout : drv;
  lhb_host_model lhb_host_model_i (.mclk(mclk), .bus(hd), .oe(oe), .sel_n(sel_n),
    .sel(sel), .spc(spc), .style(style), .rs(rs), .e_rd(e_rd), .rw_wr(rw_wr), .drv(drv));
  lhb_host_bus lhb_host_bus_i (.mclk(mclk), .reset(reset), .select_active_low(sel_n),
    .select_active_high(sel), .serial_parallel_choice(spc), .bus_style_choice(style),
    .register_or_ram_select(rs), .strobe_e_rd(e_rd), .strobe_rw_wr(rw_wr),
    .host_data_in(hd), .host_data_out(hout), .host_data_oe(oe), .serial_clk(sclk),
    .serial_data(sdat), .ram_wr_valid(wv), .ram_wr_ready(wr_rdy), .ram_wr_data(wd),
    .ram_rd_req(rdq), .ram_rd_data(rdd), .ram_addr_changed(chg), .instr_valid(iv),
    .instr_data(idat), .busy_flag(busy), .seg_dir_flag(segd), .display_on_flag(dspon),
    .reset_in_progress_flag(rstf), .serial_byte_valid(sv), .serial_byte(sbyte),
    .serial_busy(sb));
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (iv === 1'b1) n_i++;
    if (sv === 1'b1) n_s++;
    if (wv === 1'b1 && wr_rdy) wq.push_back(wd);
    if (rdq === 1'b1) begin
      rdd <= 8'ha0 + n_rd[7:0];
      n_rd++;
    end
    if (cyc == 3000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic set_style(input logic b);
    lhb_host_model_i.style = b;
    lhb_host_model_i.e_rd = ~b;
  endtask
  task automatic t_status;
    for (int s = 0; s < 2; s++) begin
      set_style(s[0]);
      {busy, segd, dspon, rstf} = s ? 4'ha : 4'h5;
      lhb_host_model_i.xfer(1'b1, 1'b0, 8'h00, q, q_oe);
      chk("status", {s ? 4'ha : 4'h5, 4'h0}, q);
      chk("read oe", 8'h01, {7'h0, q_oe});
    end
    chk("idle oe", 8'h00, {7'h0, oe});
    $display("status test done");
  endtask
  task automatic t_instr;
    n_i = 0;
    for (int s = 0; s < 2; s++) begin
      set_style(s[0]);
      lhb_host_model_i.xfer(1'b0, 1'b0, 8'h3c ^ s[7:0], q, q_oe);
      chk("instr count", s[7:0] + 8'h01, n_i[7:0]);
      chk("instr data", 8'h3c ^ s[7:0], idat);
    end
    $display("instruction test done");
  endtask
  task automatic t_ram_rd;
    set_style(1'b0);
    chg = 1'b1;
    @(negedge mclk);
    chg = 1'b0;
    for (int i = 0; i < 3; i++) begin
      lhb_host_model_i.xfer(1'b1, 1'b1, 8'h00, q, q_oe);
      chk("ram read", i == 0 ? 8'h00 : 8'h9f + i[7:0], q);
    end
    $display("ram read test done");
  endtask
  task automatic t_fifo;
    for (int i = 0; i < 5; i++) begin
      lhb_host_model_i.xfer(1'b0, 1'b1, 8'h10 + i[7:0], q, q_oe);
    end
    chk("full", 8'h01, {7'h0, sb});
    wr_rdy = 1'b1;
    repeat (10) @(negedge mclk);
    chk("drained", 8'h04, 8'(wq.size()));
    for (int i = 0; i < 4; i++) chk("ram data", 8'h10 + i[7:0], wq[i]);
    $display("write fifo test done");
  endtask
  task automatic t_desel;
    n_i = 0;
    for (int c = 0; c < 3; c++) begin
      {lhb_host_model_i.sel_n, lhb_host_model_i.sel} = 2'(6'h23 >> (c * 2));
      lhb_host_model_i.xfer(1'b0, 1'b0, 8'h77, q, q_oe);
      lhb_host_model_i.xfer(1'b1, 1'b0, 8'h00, q, q_oe);
      chk("deselected oe", 8'h00, {7'h0, q_oe});
    end
    chk("deselected instr", 8'h00, n_i[7:0]);
    {lhb_host_model_i.sel_n, lhb_host_model_i.sel} = 2'h1;
    $display("deselect test done");
  endtask
  task automatic send(input logic [7:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      sdat = v[i];
      repeat (2) @(negedge mclk);
      sclk = 1'b1;
      repeat (2) @(negedge mclk);
      sclk = 1'b0;
    end
  endtask
  task automatic t_serial;
    lhb_host_model_i.spc = 1'b0;
    n_i = 0;
    lhb_host_model_i.xfer(1'b0, 1'b0, 8'h55, q, q_oe);
    chk("serial strobe", 8'h00, n_i[7:0]);
    send(8'hff, 3);
    lhb_host_model_i.sel_n = 1'b1;
    repeat (2) @(negedge mclk);
    lhb_host_model_i.sel_n = 1'b0;
    set_style(1'b1);
    n_s = 0;
    send(8'h5a, 8);
    repeat (3) @(negedge mclk);
    chk("serial count", 8'h01, n_s[7:0]);
    chk("serial byte", 8'h5a, sbyte);
    $display("serial test done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    {lhb_host_model_i.sel_n, lhb_host_model_i.sel} = 2'h1;
    t_status();
    t_instr();
    t_ram_rd();
    t_fifo();
    t_desel();
    t_serial();
    close_out();
  end
endmodule
